//--- design/bcm_defines.vh
// Shared constants of the buck controller mode and fault logic
`ifndef BCM_DEFINES_VH
`define BCM_DEFINES_VH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define BCM_CLK_PERIOD_NS   100
`define BCM_CLK_HZ          10000000
`define BCM_CONT_FREQ_HZ    300000
`define BCM_ULTRA_MIN_HZ    25000
`define BCM_EN_OFF_NS       15000
`define BCM_OC_STREAK       2
`define BCM_DEAD_CYC        2
`define BCM_SS_STEPS        256
`define BCM_OCSET_CYC       2000
`define BCM_SS_CYC          20000
`define BCM_HOLD_CYC        1000

// ----------------------------------------------------------------------------
// APB register map
// ----------------------------------------------------------------------------
`define BCM_ADDR_CTRL       12'h000
`define BCM_ADDR_STATUS     12'h004
`define BCM_ADDR_SSREF      12'h008

// ----------------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------------
`define BCM_CTRL_ULTRA_EN   0
`define BCM_CTRL_SW_DIS     1
`define BCM_CTRL_RESET      2'h1
`define BCM_ST_OVER_V       0
`define BCM_ST_UNDER_V      1
`define BCM_ST_OVER_C       2
`define BCM_ST_PGOOD        3
`define BCM_ST_MODE_LO      4
`define BCM_ST_STATE_LO     7

`endif

//--- design/bcm_sync3.v
// Three-stage synchroniser with agreement filter, one per bit
`timescale 1ns/10ps
`default_nettype none

module bcm_sync3 #(
    parameter             WIDTH = 1,
    parameter [WIDTH-1:0] INIT  = {WIDTH{1'b0}}
) (
    // Clock and reset
    input  wire             clk,
    input  wire             reset_n,
    // Data
    input  wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : gBit
            reg s1_reg;
            reg s2_reg;
            reg s3_reg;
            reg out_reg;
            always @(posedge clk) begin
                if (!reset_n) begin
                    s1_reg  <= INIT[i];
                    s2_reg  <= INIT[i];
                    s3_reg  <= INIT[i];
                    out_reg <= INIT[i];
                end else begin
                    s1_reg <= asyncIn[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    // Only a level seen on two stages counts
                    if (s2_reg == s3_reg) begin
                        out_reg <= s3_reg;
                    end
                end
            end
            assign syncOut[i] = out_reg;
        end
    endgenerate

endmodule // bcm_sync3
`default_nettype wire

//--- design/bcm_dead_time.v
// Non-overlapping gate command stage with dead time
`timescale 1ns/10ps
`default_nettype none

module bcm_dead_time #(
    parameter DEAD_CYC = 2
) (
    // Clock and reset
    input  wire clk,
    input  wire reset_n,
    // Requests
    input  wire hsReq,
    input  wire lsReq,
    input  wire lsHiZ,
    // Gate commands
    output reg  hsGate,
    output reg  lsGate,
    output reg  lsGateOe_n
);

    reg  [7:0] offCnt_reg;
    wire       deadDone = (offCnt_reg >= DEAD_CYC[7:0]);

    always @(posedge clk) begin
        if (!reset_n) begin
            hsGate     <= 1'b0;
            lsGate     <= 1'b0;
            lsGateOe_n <= 1'b0;
            offCnt_reg <= 8'h00;
        end else begin
            lsGateOe_n <= lsHiZ;
            // Turn-off is immediate, turn-on waits out the dead time
            hsGate <= hsReq & ~lsReq & (hsGate | (~lsGate & deadDone));
            lsGate <= lsReq & ~hsReq & ~lsHiZ & (lsGate | (~hsGate & deadDone));
            if (hsGate | lsGate) begin
                offCnt_reg <= 8'h00;
            end else if (!deadDone) begin
                offCnt_reg <= offCnt_reg + 8'h01;
            end
        end
    end

endmodule // bcm_dead_time
`default_nettype wire

//--- design/bcm_mode_fault.v
// Buck controller sequencing, mode selection and latched protections
`timescale 1ns/10ps
`default_nettype none
`include "bcm_defines.vh"

// Overview of operation
// - supply good starts; supply loss stops, clears latches
// - wait threshold-setting delay before soft-start
// - soft-start reference ramps monotonically from zero
// - soft-start diode emulation, then continuous, then auto
// - light load: diode emulation, low side cut
// - emulation on-time derived from input, output voltage
// - continuous current selects fixed-frequency PWM
// - ultrasonic mode keeps frequency above audio
// - ultrasonic: oscillator low side, on-time, low side
// - no zero crossing leaves ultrasonic for continuous
// - pre-charged output never discharged at start
// - enable low turns gates off after delay
// - enable release restarts soft-start
// - power-good released only inside feedback window
// - over-voltage: high low, low high until discharged
// - over-voltage latched until supply cycles
// - under-voltage turns gates off, masked in soft-start
// - under-voltage latched, no retry until supply cycles
// - sample valley current before low side off
// - two consecutive valley overs trip over-current
// - over-current latched until supply cycles
// - threshold setting: high low, low side floating
// - never both gates, dead time between them
module bcm_mode_fault #(
    parameter OCSET_CYC = `BCM_OCSET_CYC,
    parameter SS_CYC    = `BCM_SS_CYC,
    parameter HOLD_CYC  = `BCM_HOLD_CYC
) (
    // Clock and reset
    input  wire        clk,
    input  wire        reset_n,
    // APB slave
    input  wire [11:0] paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Comparator results, asynchronous
    input  wire        vccAbovePor,
    input  wire        enableLevel,
    input  wire        feedbackOverVolt,
    input  wire        feedbackUnderVolt,
    input  wire        feedbackInWindow,
    input  wire        feedbackBelowRef,
    input  wire        feedbackBelowDischarge,
    input  wire        zeroCross,
    input  wire        pwmTrip,
    input  wire        valleyOverThreshold,
    // Digitised converter voltages, same clock
    input  wire [7:0]  vinCode,
    input  wire [7:0]  voutCode,
    // Power stage and analog helpers
    output wire        highSideGateCmd,
    output wire        lowSideGateCmd,
    output wire        lowSideGateOe_n,
    output reg         ocSetSourceOn,
    output reg         valleySampleStrobe,
    output reg  [7:0]  softStartRef,
    output wire        pgoodOut,
    output reg         pgoodOe_n
);

    // ------------------------------------------------------------------------
    // Derived timing
    // ------------------------------------------------------------------------
    localparam integer PERIOD_CYC  = `BCM_CLK_HZ / `BCM_CONT_FREQ_HZ;
    localparam integer ULTRA_CYC   = `BCM_CLK_HZ / `BCM_ULTRA_MIN_HZ;
    localparam integer EN_OFF_CYC  = (`BCM_EN_OFF_NS + `BCM_CLK_PERIOD_NS - 1)
                                     / `BCM_CLK_PERIOD_NS;
    localparam integer MAXON_CYC   = PERIOD_CYC - 2 * `BCM_DEAD_CYC;
    localparam integer SS_STEP_CYC = SS_CYC / `BCM_SS_STEPS;

    localparam [5:0] S_OFF   = 6'h01;
    localparam [5:0] S_OCSET = 6'h02;
    localparam [5:0] S_SOFT  = 6'h04;
    localparam [5:0] S_HOLD  = 6'h08;
    localparam [5:0] S_RUN   = 6'h10;
    localparam [5:0] S_FAULT = 6'h20;

    localparam [2:0] OP_DIODE = 3'h1;
    localparam [2:0] OP_CONT  = 3'h2;
    localparam [2:0] OP_ULTRA = 3'h4;

    localparam [3:0] P_IDLE   = 4'h1;
    localparam [3:0] P_HIGH   = 4'h2;
    localparam [3:0] P_LOW    = 4'h4;
    localparam [3:0] P_OSCLOW = 4'h8;

    // ------------------------------------------------------------------------
    // Comparator synchronisers
    // ------------------------------------------------------------------------
    wire [9:0] cmpSync;
    bcm_sync3 #(.WIDTH(10), .INIT(10'h000)) uSync (
        .clk     (clk),
        .reset_n (reset_n),
        .asyncIn ({valleyOverThreshold, pwmTrip, zeroCross, feedbackBelowDischarge,
                   feedbackBelowRef, feedbackInWindow, feedbackUnderVolt,
                   feedbackOverVolt, enableLevel, vccAbovePor}),
        .syncOut (cmpSync)
    );
    wire vccOk    = cmpSync[0];
    wire enIn     = cmpSync[1];
    wire overV    = cmpSync[2];
    wire underV   = cmpSync[3];
    wire inWindow = cmpSync[4];
    wire belowRef = cmpSync[5];
    wire belowDis = cmpSync[6];
    wire zeroX    = cmpSync[7];
    wire pwmEnd   = cmpSync[8];
    wire valleyHi = cmpSync[9];

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    reg  [5:0]  state_reg;
    reg  [5:0]  state_next;
    reg  [2:0]  opMode_reg;
    reg  [3:0]  phase_reg;
    reg  [1:0]  ctrl_reg;
    reg         overvoltageLatch_reg;
    reg         undervoltageLatch_reg;
    reg         overcurrentLatch_reg;
    reg         dischargeOn_reg;
    reg         ocsetDone_reg;
    reg  [1:0]  ocStreak_reg;
    reg  [15:0] timer_reg;
    reg  [15:0] enOffCnt_reg;
    reg  [15:0] periodCnt_reg;
    reg  [15:0] onCnt_reg;
    reg  [15:0] idleCnt_reg;
    reg  [15:0] cotAcc_reg;

    wire anyLatch = overvoltageLatch_reg | undervoltageLatch_reg | overcurrentLatch_reg;
    wire active   = |(state_reg & (S_SOFT | S_HOLD | S_RUN));
    wire enLevel  = enIn & ~ctrl_reg[`BCM_CTRL_SW_DIS];
    wire offDone  = (enOffCnt_reg == EN_OFF_CYC[15:0] - 16'd1);
    wire stepTick = (state_reg == S_SOFT) & (timer_reg == SS_STEP_CYC[15:0] - 16'd1);
    wire ssDone   = stepTick & (softStartRef == 8'hff);

    // Mode of the switching engine for the current state
    wire inRun     = (state_reg == S_RUN);
    wire fixedFreq = (state_reg == S_SOFT) | (state_reg == S_HOLD)
                   | (inRun & (opMode_reg == OP_CONT));
    wire diodeStop = (state_reg == S_SOFT) | (inRun & (opMode_reg != OP_CONT));
    wire periodStart = fixedFreq & (periodCnt_reg == 16'd0);

    // Constant on-time: input code accumulates to period times output code
    wire [15:0] cotGoal = voutCode * PERIOD_CYC[7:0];
    wire        cotDone = (cotAcc_reg >= cotGoal) | (onCnt_reg >= MAXON_CYC[15:0]);
    wire        pwmDone = pwmEnd | (onCnt_reg >= MAXON_CYC[15:0]);

    wire lowExit = (phase_reg == P_LOW)
                 & ((diodeStop & zeroX) | periodStart | (inRun & belowRef));

    // Protection triggers
    wire ovTrip = active & overV;
    wire uvTrip = ((state_reg == S_HOLD) | inRun) & underV;
    wire ocTrip = lowExit & valleyHi & (ocStreak_reg == `BCM_OC_STREAK - 1);

    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    always @* begin
        state_next = state_reg;
        case (state_reg)
            S_OFF: begin
                if (!anyLatch && !ocsetDone_reg) begin
                    state_next = S_OCSET;
                end else if (!anyLatch && enLevel) begin
                    state_next = S_SOFT;
                end
            end
            S_OCSET: begin
                if (timer_reg == OCSET_CYC[15:0] - 16'd1) begin
                    state_next = enLevel ? S_SOFT : S_OFF;
                end
            end
            S_SOFT: begin
                if (ssDone) begin
                    state_next = S_HOLD;
                end
            end
            S_HOLD: begin
                if (timer_reg == HOLD_CYC[15:0] - 16'd1) begin
                    state_next = S_RUN;
                end
            end
            S_RUN: begin
                state_next = S_RUN;
            end
            S_FAULT: begin
                state_next = S_FAULT;
            end
            default: begin
                state_next = S_OFF;
            end
        endcase
        if (!vccOk) begin
            state_next = S_OFF;
        end else if (anyLatch) begin
            state_next = S_FAULT;
        end else if (active && !enLevel && offDone) begin
            state_next = S_OFF;
        end
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            state_reg             <= S_OFF;
            overvoltageLatch_reg  <= 1'b0;
            undervoltageLatch_reg <= 1'b0;
            overcurrentLatch_reg  <= 1'b0;
            dischargeOn_reg       <= 1'b0;
            ocsetDone_reg         <= 1'b0;
            timer_reg             <= 16'h0000;
            enOffCnt_reg          <= 16'h0000;
            softStartRef          <= 8'h00;
            ocSetSourceOn         <= 1'b0;
        end else begin
            state_reg     <= state_next;
            ocSetSourceOn <= (state_next == S_OCSET);
            if (state_next != state_reg || stepTick) begin
                timer_reg <= 16'h0000;
            end else begin
                timer_reg <= timer_reg + 16'h0001;
            end
            if (active && !enLevel && !offDone) begin
                enOffCnt_reg <= enOffCnt_reg + 16'h0001;
            end else begin
                enOffCnt_reg <= 16'h0000;
            end
            if (state_reg == S_OCSET) begin
                ocsetDone_reg <= 1'b1;
            end
            // Ramp only climbs; restarts from zero on each new soft-start
            if (state_reg != S_SOFT && state_next == S_SOFT) begin
                softStartRef <= 8'h00;
            end else if (state_reg == S_SOFT && stepTick && softStartRef != 8'hff) begin
                softStartRef <= softStartRef + 8'h01;
            end else if (state_reg == S_OFF || state_reg == S_OCSET) begin
                softStartRef <= 8'h00;
            end
            if (!vccOk) begin
                // Supply loss is the only way out of a latched fault
                overvoltageLatch_reg  <= 1'b0;
                undervoltageLatch_reg <= 1'b0;
                overcurrentLatch_reg  <= 1'b0;
                dischargeOn_reg       <= 1'b0;
                ocsetDone_reg         <= 1'b0;
            end else begin
                if (ovTrip) begin
                    overvoltageLatch_reg <= 1'b1;
                end
                if (uvTrip) begin
                    undervoltageLatch_reg <= 1'b1;
                end
                if (ocTrip) begin
                    overcurrentLatch_reg <= 1'b1;
                end
                if (ovTrip) begin
                    dischargeOn_reg <= 1'b1;
                end else if (belowDis) begin
                    dischargeOn_reg <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Switching engine
    // ------------------------------------------------------------------------
    always @(posedge clk) begin
        if (!reset_n || !active || anyLatch) begin
            phase_reg          <= P_IDLE;
            opMode_reg         <= OP_DIODE;
            periodCnt_reg      <= 16'h0000;
            onCnt_reg          <= 16'h0000;
            idleCnt_reg        <= 16'h0000;
            cotAcc_reg         <= 16'h0000;
            ocStreak_reg       <= 2'h0;
            valleySampleStrobe <= 1'b0;
        end else begin
            if (periodCnt_reg == PERIOD_CYC[15:0] - 16'd1) begin
                periodCnt_reg <= 16'h0000;
            end else begin
                periodCnt_reg <= periodCnt_reg + 16'h0001;
            end
            if (phase_reg == P_HIGH) begin
                onCnt_reg  <= onCnt_reg + 16'h0001;
                cotAcc_reg <= cotAcc_reg + {8'h00, vinCode};
            end else begin
                onCnt_reg  <= 16'h0000;
                cotAcc_reg <= 16'h0000;
            end
            if (phase_reg == P_IDLE) begin
                idleCnt_reg <= idleCnt_reg + 16'h0001;
            end else begin
                idleCnt_reg <= 16'h0000;
            end
            if (!inRun) begin
                opMode_reg <= (state_reg == S_SOFT) ? OP_DIODE : OP_CONT;
            end
            // Valley current is judged at the last cycle of each low-side pulse, except oscillator pulses and continuous pulses ended by a zero crossing
            valleySampleStrobe <= lowExit;
            if (lowExit) begin
                ocStreak_reg <= valleyHi ? ocStreak_reg + 2'h1 : 2'h0;
            end
            case (phase_reg)
                P_IDLE: begin
                    // Low side waits for a first high pulse: pre-charge is kept
                    if (fixedFreq ? periodStart : belowRef) begin
                        phase_reg <= P_HIGH;
                    end else if (inRun && opMode_reg == OP_ULTRA
                                 && idleCnt_reg >= ULTRA_CYC[15:0] - 16'd1) begin
                        phase_reg <= P_OSCLOW;
                    end
                end
                P_HIGH: begin
                    if (fixedFreq ? pwmDone : cotDone) begin
                        phase_reg <= P_LOW;
                    end
                end
                P_LOW: begin
                    if (diodeStop && zeroX) begin
                        phase_reg <= P_IDLE;
                    end else if (inRun && opMode_reg == OP_CONT && zeroX) begin
                        phase_reg  <= P_IDLE;
                        opMode_reg <= ctrl_reg[`BCM_CTRL_ULTRA_EN] ? OP_ULTRA : OP_DIODE;
                    end else if (periodStart) begin
                        phase_reg <= P_HIGH;
                    end else if (inRun && belowRef) begin
                        // Next pulse due before current reached zero
                        phase_reg  <= P_HIGH;
                        opMode_reg <= OP_CONT;
                    end
                end
                P_OSCLOW: begin
                    if (belowRef) begin
                        phase_reg <= P_HIGH;
                    end
                end
                default: begin
                    phase_reg <= P_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Gate drive
    // ------------------------------------------------------------------------
    wire drive = active & ~anyLatch;
    wire hsReq = drive & (phase_reg == P_HIGH);
    wire lsReq = (drive & ((phase_reg == P_LOW) | (phase_reg == P_OSCLOW)))
               | ((state_reg == S_FAULT) & overvoltageLatch_reg & dischargeOn_reg);

    bcm_dead_time #(.DEAD_CYC(`BCM_DEAD_CYC)) high_side_gate_cmd (
        .clk        (clk),
        .reset_n    (reset_n),
        .hsReq      (hsReq),
        .lsReq      (lsReq),
        .lsHiZ      (state_reg == S_OCSET),
        .hsGate     (highSideGateCmd),
        .lsGate     (lowSideGateCmd),
        .lsGateOe_n (lowSideGateOe_n)
    );

    // ------------------------------------------------------------------------
    // Power good, open drain
    // ------------------------------------------------------------------------
    assign pgoodOut = 1'b0;
    always @(posedge clk) begin
        if (!reset_n) begin
            pgoodOe_n <= 1'b0;
        end else begin
            pgoodOe_n <= inWindow & ~anyLatch;
        end
    end

    // ------------------------------------------------------------------------
    // APB registers
    // ------------------------------------------------------------------------
    wire mapped = (paddr == `BCM_ADDR_CTRL) | (paddr == `BCM_ADDR_STATUS)
                | (paddr == `BCM_ADDR_SSREF);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    always @(posedge clk) begin
        if (!reset_n) begin
            ctrl_reg <= `BCM_CTRL_RESET;
            prdata   <= 32'h00000000;
        end else begin
            if (psel && penable && pwrite && paddr == `BCM_ADDR_CTRL) begin
                ctrl_reg <= pwdata[1:0];
            end
            if (psel && !penable) begin
                if (paddr == `BCM_ADDR_CTRL) begin
                    prdata <= {30'h0, ctrl_reg};
                end else if (paddr == `BCM_ADDR_STATUS) begin
                    prdata <= {19'h0, state_reg, opMode_reg, ~pgoodOe_n == 1'b0,
                               overcurrentLatch_reg, undervoltageLatch_reg,
                               overvoltageLatch_reg};
                end else if (paddr == `BCM_ADDR_SSREF) begin
                    prdata <= {24'h0, softStartRef};
                end else begin
                    prdata <= 32'h00000000;
                end
            end
        end
    end

endmodule // bcm_mode_fault
`default_nettype wire

//--- tb/bcm_mode_fault_sva.sv
// Port assertions of the mode and fault block
`timescale 1ns/10ps
`default_nettype none
module bcm_mode_fault_sva (
    // Clock and reset
    input wire logic       clk,
    input wire logic       reset_n,
    // Watched ports
    input wire logic       vccAbovePor,
    input wire logic       enableLevel,
    input wire logic       feedbackInWindow,
    input wire logic       highSideGateCmd,
    input wire logic       lowSideGateCmd,
    input wire logic       lowSideGateOe_n,
    input wire logic       ocSetSourceOn,
    input wire logic [7:0] softStartRef,
    input wire logic       pgoodOe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Saturating count of enable-low cycles
    logic [7:0] offCnt;
    always_ff @(posedge clk)
        offCnt <= (!reset_n || enableLevel) ? 8'h00 : offCnt + {7'h00, offCnt != 8'hff};
    sequence hsOff2; !highSideGateCmd [*2]; endsequence
    sequence lsOff2; !lowSideGateCmd [*2]; endsequence
    chk_gate_overlap: assert property (!(highSideGateCmd && lowSideGateCmd))
        else $error("gates overlap");
    chk_dead_low: assert property ($fell(lowSideGateCmd) |-> hsOff2)
        else $error("no dead time");
    chk_dead_high: assert property ($fell(highSideGateCmd) |-> lsOff2)
        else $error("no dead time");
    chk_por_off: assert property (!vccAbovePor [*8] |-> !highSideGateCmd && !lowSideGateCmd)
        else $error("switching without supply");
    chk_ocset_float: assert property (ocSetSourceOn [*2] |-> lowSideGateOe_n && !highSideGateCmd)
        else $error("setting drive");
    chk_ref_step: assert property ($changed(softStartRef) |->
        softStartRef == $past(softStartRef) + 8'h01 || softStartRef == 8'h00)
        else $error("ref step");
    chk_pgood_low: assert property (!feedbackInWindow [*8] |-> !pgoodOe_n)
        else $error("power good released");
    chk_enable_off: assert property (offCnt > 8'hb4 |-> !highSideGateCmd && !lowSideGateCmd)
        else $error("gates on while disabled");
endmodule // bcm_mode_fault_sva
bind bcm_mode_fault bcm_mode_fault_sva u_sva (.*);
`default_nettype wire

//--- tb/bcm_stage_model.sv
// Behavioural power stage and feedback network
`timescale 1ns/10ps
`default_nettype none
module bcm_stage_model (
    // Gate commands and fault injection
    input  wire logic clk,
    input  wire logic highSideGateCmd,
    input  wire logic lowSideGateCmd,
    input  wire logic ovForce,
    input  wire logic ocForce,
    // Comparator levels
    output wire logic feedbackBelowRef,
    output wire logic feedbackInWindow,
    output wire logic feedbackOverVolt,
    output wire logic feedbackUnderVolt,
    output wire logic feedbackBelowDischarge,
    output wire logic pwmTrip,
    output wire logic valleyOverThreshold
);
    // Reference sits at 1000; the load drains slowly so levels never chatter
    int vout = 0;
    logic [1:0] tick = 2'h0;
    always @(posedge clk) begin
        tick <= tick + 2'h1;
        if (highSideGateCmd)
            vout <= vout + 8;
        else if (vout > 0 && tick == 2'h0)
            vout <= vout - 1;
    end
    assign feedbackBelowRef = vout < 1000;
    assign pwmTrip = vout >= 1000;
    assign feedbackInWindow = vout > 880 && vout < 1120;
    assign feedbackOverVolt = ovForce || vout > 1250;
    assign feedbackUnderVolt = vout < 500;
    assign feedbackBelowDischarge = vout < 400;
    assign valleyOverThreshold = ocForce;
endmodule // bcm_stage_model
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench of the mode and fault block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic e;} bcm_row_t;
    bcm_row_t rows [5] = '{'{1'b0, 12'h000, 32'h1, 1'b0}, '{1'b1, 12'h000, 32'h0, 1'b0},
        '{1'b0, 12'h000, 32'h0, 1'b0}, '{1'b1, 12'h000, 32'h1, 1'b0},
        '{1'b0, 12'h00c, 32'h0, 1'b1}};
    logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic vccAbovePor = 1'b0, enableLevel = 1'b1, zeroCross = 1'b0, ovForce = 1'b0;
    logic ocForce = 1'b0, e;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    logic [7:0] vinCode = 8'h78, voutCode = 8'h0c;
    wire logic [31:0] prdata;
    wire logic [7:0] softStartRef;
    wire logic pready, pslverr, highSideGateCmd, lowSideGateCmd, lowSideGateOe_n;
    wire logic ocSetSourceOn, valleySampleStrobe, pgoodOut, pgoodOe_n, pwmTrip;
    wire logic feedbackOverVolt, feedbackUnderVolt, feedbackInWindow, feedbackBelowRef;
    wire logic feedbackBelowDischarge, valleyOverThreshold;
    int bad_count = 0, compares = 0, n;
    bcm_mode_fault #(.OCSET_CYC(20), .SS_CYC(512), .HOLD_CYC(50)) DUT (.*);
    bcm_stage_model PS (.*);
    initial forever #50 clk = ~clk;
    task chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task final_report;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) @(posedge clk) if (pready === 1'b1) break;
        chk(n < 20, "no ready");
        rd = prdata; e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    initial begin
        repeat (90000) @(posedge clk);
        chk(1'b0, "timeout");
        final_report;
    end
    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        foreach (rows[i]) begin
            pwdata <= rows[i].d;
            apb(rows[i].w, rows[i].a);
            chk(e === rows[i].e && (rows[i].w || rd === rows[i].d), "register row");
        end
        for (int f = 0; f < 2; f++) begin
            vccAbovePor <= 1'b1;
            for (n = 0; n < 40 && ocSetSourceOn !== 1'b1; n++) @(posedge clk);
            @(posedge clk);
            chk(lowSideGateOe_n === 1'b1 && highSideGateCmd === 1'b0, "setting");
            for (n = 0; n < 60 && ocSetSourceOn === 1'b1; n++) @(posedge clk);
            chk(n >= 18 && softStartRef === 8'h00, "setting delay");
            for (n = 0; n < 9000 && softStartRef !== 8'hff; n++) @(posedge clk);
            chk(softStartRef === 8'hff, "ramp");
            if (f == 0) begin
                enableLevel <= 1'b0;
                repeat (200) @(posedge clk);
                chk(highSideGateCmd === 1'b0 && lowSideGateCmd === 1'b0, "disable");
                enableLevel <= 1'b1;
                for (n = 0; n < 300 && softStartRef !== 8'h01; n++) @(posedge clk);
                chk(softStartRef === 8'h01, "restart");
                for (n = 0; n < 9000 && softStartRef !== 8'hff; n++) @(posedge clk);
            end
            repeat (300) @(posedge clk);
            chk(pgoodOe_n === 1'b1, "power good");
            for (n = 0; n < 40 && valleySampleStrobe !== 1'b1; n++) @(posedge clk);
            chk(n < 40, "strobe");
            if (f == 0) ocForce <= 1'b1; else ovForce <= 1'b1;
            repeat (20) @(posedge clk);
            if (f == 1) chk(highSideGateCmd === 1'b0 && lowSideGateCmd === 1'b1, "ov");
            repeat (130) @(posedge clk);
            ocForce <= 1'b0; ovForce <= 1'b0;
            repeat (f ? 3000 : 700) @(posedge clk);
            chk(highSideGateCmd === 1'b0 && lowSideGateCmd === 1'b0, "latch");
            apb(1'b0, 12'h004);
            chk(rd[f ? 0 : 2] === 1'b1 && pgoodOe_n === 1'b0, "fault");
            vccAbovePor <= 1'b0;
            repeat (20) @(posedge clk);
            apb(1'b0, 12'h004);
            chk(rd[2:0] === 3'h0, "clear");
        end
        final_report;
    end
endmodule // testbench
`default_nettype wire
